// ---- src/rswc_defs.vh ----
// Purpose: Constants for the reset source and watchdog controller
// Assumes: 40 MHz system clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words
`ifndef RSWC_DEFS_VH
`define RSWC_DEFS_VH
// ============================================================
// Clock and timing
`define RSWC_CLK_HZ     40000000
`define RSWC_CLK_MHZ    40
`define RSWC_TOUT_NS    64000
`define RSWC_TOUT_CYC   ((`RSWC_TOUT_NS*`RSWC_CLK_MHZ+999)/1000)
`define RSWC_WDOSC_HZ   128000
`define RSWC_WDOSC_DIV  (`RSWC_CLK_HZ/`RSWC_WDOSC_HZ)
`define RSWC_UNLOCK_CYC 3'h4
`define RSWC_UNLOCK_SIG 8'hd8
`define RSWC_WDT_BASE   21'h000800
`define RSWC_WDP_MAX    4'h9
// ============================================================
// Register offsets
`define RSWC_OFS_WDT    8'h00
`define RSWC_OFS_MON    8'h04
`define RSWC_OFS_FLG    8'h08
`define RSWC_OFS_UNLK   8'h0c
// ============================================================
// Watchdog control fields
`define RSWC_WD_IRQF    7
`define RSWC_WD_IRQE    6
`define RSWC_WD_P3      5
`define RSWC_WD_EN      3
// Supply monitor fields
`define RSWC_MON_FLAG   7
`define RSWC_MON_IRQE   6
`define RSWC_LVL_OFF    3'h0
`define RSWC_LVL_RST1   3'h1
`define RSWC_LVL_RST2   3'h2
`define RSWC_LVL_FLG1   3'h3
`define RSWC_LVL_FLG2   3'h4
// Reset cause flag fields
`define RSWC_FL_POR     0
`define RSWC_FL_EXT     1
`define RSWC_FL_WDT     3
`endif

// ---- src/rswc_top.v ----
// Purpose: Reset sources, start-up delay, supply monitor, watchdog
// Assumes: one instruction cycle equals one clk_sys cycle
// Notes:   Registers on APB; core reset output is active low
`include "rswc_defs.vh"

module rswc_top
#(
    parameter TOUT_CYC = `RSWC_TOUT_CYC
)
(
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Supply detection
    input  wire        supplyBelowPot,
    input  wire        supplyBelowLevel,
    output reg  [2:0]  supplyLevelSelect,
    // External reset pin
    input  wire        resetPinN,
    input  wire        extResetEnable,
    // Watchdog fuse and core events
    input  wire        wdtAlwaysOnFuse,
    input  wire        wdtRestart,
    input  wire        wdtIrqAck,
    // Towards the core
    output reg         coreResetN_r,
    output reg         wdtIrq_r,
    output reg         lowSupplyIrq_r
);

    // ============================================================
    // States, one-hot
    localparam [4:0] S_HOLD = 5'b00001;
    localparam [4:0] S_POR  = 5'b00010;
    localparam [4:0] S_DLY  = 5'b00100;
    localparam [4:0] S_RUN  = 5'b01000;
    localparam [4:0] S_WPUL = 5'b10000;
    // Full width first, then cut to the counter widths on purpose
    localparam [31:0] TOUT_LAST_W = TOUT_CYC - 1;
    localparam [31:0] DIV_LAST_W  = `RSWC_WDOSC_DIV - 1;
    localparam [11:0] TOUT_LAST   = TOUT_LAST_W[11:0];
    localparam [8:0]  DIV_LAST    = DIV_LAST_W[8:0];

    reg  [4:0]  state_r;
    reg  [4:0]  state_nxt;
    reg  [11:0] dlyCnt_r;
    reg  [11:0] dlyCnt_nxt;
    reg         porSeen_r;
    reg         porSeen_nxt;
    reg  [8:0]  divCnt_r;
    reg  [20:0] wdtCnt_r;
    reg         wdtEn_r;
    reg         wdtIrqEn_r;
    reg         wdtIrqFlag_r;
    reg  [3:0]  wdtPre_r;
    reg  [2:0]  unlockCnt_r;
    reg         monIrqEn_r;
    reg         lowFlag_r;
    reg         trigDly_r;
    reg         flagPor_r;
    reg         flagExt_r;
    reg         flagWdt_r;
    reg         wdtResetEv;
    reg         setPor;
    reg         setExt;

    // ============================================================
    // Bus decode
    wire        busAcc  = psel & penable & pready;
    wire        busWr   = busAcc & pwrite;
    wire        wrWdt   = busWr & (paddr == `RSWC_OFS_WDT);
    wire        wrMon   = busWr & (paddr == `RSWC_OFS_MON);
    wire        wrFlg   = busWr & (paddr == `RSWC_OFS_FLG);
    wire        wrUnlk  = busWr & (paddr == `RSWC_OFS_UNLK);

    // ============================================================
    // Reset sources
    wire vlmRstLvl = (supplyLevelSelect == `RSWC_LVL_RST1) |
                     (supplyLevelSelect == `RSWC_LVL_RST2);
    wire porSrc = supplyBelowPot |
                  (vlmRstLvl & supplyBelowLevel);
    wire pinSrc = extResetEnable & ~resetPinN;
    wire intRst = ~state_r[3];
    wire fuse   = wdtAlwaysOnFuse;

    // Pin path bypasses the clock; gated off in power-up count
    wire pinRstN = rst_n & ~(pinSrc & ~state_r[1]);

    // ============================================================
    // Reset sequencer
    always @*
    begin
        state_nxt   = state_r;
        dlyCnt_nxt  = dlyCnt_r;
        porSeen_nxt = porSeen_r;
        setPor      = 1'b0;
        setExt      = 1'b0;
        if (porSrc)
        begin
            // Re-asserts at once from any state
            state_nxt   = S_HOLD;
            porSeen_nxt = 1'b1;
        end
        else
        begin
            case (state_r)
                S_HOLD:
                begin
                    dlyCnt_nxt = 12'h000;
                    if (porSeen_r)
                    begin
                        state_nxt = S_POR;
                        setPor    = 1'b1;
                    end
                    else if (!pinSrc)
                        state_nxt = S_DLY;
                end
                S_POR:
                begin
                    // Pin is not looked at until count ends
                    dlyCnt_nxt = dlyCnt_r + 12'h001;
                    if (dlyCnt_r == TOUT_LAST)
                    begin
                        porSeen_nxt = 1'b0;
                        if (pinSrc)
                        begin
                            state_nxt = S_HOLD;
                            setExt    = 1'b1;
                        end
                        else
                            state_nxt = S_RUN;
                    end
                end
                S_DLY:
                begin
                    dlyCnt_nxt = dlyCnt_r + 12'h001;
                    if (pinSrc)
                    begin
                        state_nxt = S_HOLD;
                        setExt    = 1'b1;
                    end
                    else if (dlyCnt_r == TOUT_LAST)
                        state_nxt = S_RUN;
                end
                S_RUN:
                begin
                    if (pinSrc)
                    begin
                        state_nxt = S_HOLD;
                        setExt    = 1'b1;
                    end
                    else if (wdtResetEv)
                        state_nxt = S_WPUL;
                end
                S_WPUL:
                begin
                    // One cycle pulse; delay starts at its end
                    dlyCnt_nxt = 12'h000;
                    state_nxt  = S_DLY;
                end
                default:
                    state_nxt = S_HOLD;
            endcase
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r   <= S_HOLD;
            dlyCnt_r  <= 12'h000;
            porSeen_r <= 1'b1;
        end
        else
        begin
            state_r   <= state_nxt;
            dlyCnt_r  <= dlyCnt_nxt;
            porSeen_r <= porSeen_nxt;
        end
    end

    // Core reset; pin clears it even with the clock stopped
    always @(posedge clk_sys or negedge pinRstN)
    begin
        if (!pinRstN)
            coreResetN_r <= 1'b0;
        else
            coreResetN_r <= (state_nxt == S_RUN);
    end

    // ============================================================
    // Watchdog oscillator tick, derived by divider
    wire wdTick = (divCnt_r == DIV_LAST);
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            divCnt_r <= 9'h000;
        else if (wdTick)
            divCnt_r <= 9'h000;
        else
            divCnt_r <= divCnt_r + 9'h001;
    end

    // Watchdog period; reserved codes act as the longest
    wire [3:0]  wdpEff  = (wdtPre_r > `RSWC_WDP_MAX) ?
                          `RSWC_WDP_MAX : wdtPre_r;
    wire [20:0] wdtLast = (`RSWC_WDT_BASE << wdpEff) - 21'h1;
    wire wdtEnEff = fuse | wdtEn_r | flagWdt_r;
    wire wdtIrqMd = wdtIrqEn_r & ~fuse;
    wire wdtRun   = wdtEnEff | wdtIrqMd;
    wire wdtExp   = wdtRun & wdTick & (wdtCnt_r == wdtLast);
    wire wdtIrqEv = wdtExp & wdtIrqMd;
    wire unlocked = (unlockCnt_r != 3'h0);

    always @*
        wdtResetEv = wdtExp & ~wdtIrqMd & wdtEnEff;

    // Counter
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            wdtCnt_r <= 21'h000000;
        else if (intRst | wdtRestart | ~wdtRun | wdtExp)
            wdtCnt_r <= 21'h000000;
        else if (wdTick)
            wdtCnt_r <= wdtCnt_r + 21'h000001;
    end

    // Unlock window, closed by time or by a control write
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            unlockCnt_r <= 3'h0;
        else if (wrUnlk && pwdata[7:0] == `RSWC_UNLOCK_SIG)
            unlockCnt_r <= `RSWC_UNLOCK_CYC;
        else if (wrWdt | intRst)
            unlockCnt_r <= 3'h0;
        else if (unlocked)
            unlockCnt_r <= unlockCnt_r - 3'h1;
    end

    // Watchdog control register
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdtEn_r      <= 1'b0;
            wdtIrqEn_r   <= 1'b0;
            wdtIrqFlag_r <= 1'b0;
            wdtPre_r     <= 4'h0;
        end
        else if (intRst)
        begin
            wdtEn_r      <= 1'b0;
            wdtIrqEn_r   <= 1'b0;
            wdtIrqFlag_r <= 1'b0;
            wdtPre_r     <= 4'h0;
        end
        else
        begin
            if (wrWdt)
            begin
                wdtIrqEn_r <= pwdata[`RSWC_WD_IRQE];
                if (!fuse || unlocked)
                    wdtPre_r <= {pwdata[`RSWC_WD_P3],
                                 pwdata[2:0]};
                // Level 2 ignores the enable bit entirely
                if (!fuse && (pwdata[`RSWC_WD_EN] || unlocked))
                    wdtEn_r <= pwdata[`RSWC_WD_EN];
            end
            else if (wdtIrqAck && wdtEnEff)
                wdtIrqEn_r <= 1'b0;
            // Set wins over write-one and service clear
            if (wdtIrqEv)
                wdtIrqFlag_r <= 1'b1;
            else if (wdtIrqAck ||
                     (wrWdt && pwdata[`RSWC_WD_IRQF]))
                wdtIrqFlag_r <= 1'b0;
        end
    end

    // ============================================================
    // Supply level monitor
    wire lvlFlagMd = (supplyLevelSelect == `RSWC_LVL_FLG1) |
                     (supplyLevelSelect == `RSWC_LVL_FLG2);
    wire trig      = lvlFlagMd & supplyBelowLevel;
    wire lvlChg    = wrMon & (pwdata[2:0] != supplyLevelSelect);

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            supplyLevelSelect <= `RSWC_LVL_OFF;
            monIrqEn_r        <= 1'b0;
            lowFlag_r         <= 1'b0;
            trigDly_r         <= 1'b0;
        end
        else
        begin
            trigDly_r <= trig;
            if (wrMon)
            begin
                monIrqEn_r <= pwdata[`RSWC_MON_IRQE];
                // Illegal codes are refused, old level kept
                if (pwdata[2:0] <= `RSWC_LVL_FLG2)
                    supplyLevelSelect <= pwdata[2:0];
            end
            // New crossing sets; set wins over any clear
            if (trig && !trigDly_r)
                lowFlag_r <= 1'b1;
            else if (!trig || lvlChg ||
                     (wrMon && !pwdata[`RSWC_MON_FLAG]))
                lowFlag_r <= 1'b0;
        end
    end

    // ============================================================
    // Reset cause flags, cleared by writing zero
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flagPor_r <= 1'b1;
            flagExt_r <= 1'b0;
            flagWdt_r <= 1'b0;
        end
        else
        begin
            if (setPor)
                flagPor_r <= 1'b1;
            else if (wrFlg && !pwdata[`RSWC_FL_POR])
                flagPor_r <= 1'b0;
            if (setExt)
                flagExt_r <= 1'b1;
            else if (wrFlg && !pwdata[`RSWC_FL_EXT])
                flagExt_r <= 1'b0;
            if (wdtResetEv)
                flagWdt_r <= 1'b1;
            else if (wrFlg && !pwdata[`RSWC_FL_WDT])
                flagWdt_r <= 1'b0;
        end
    end

    // ============================================================
    // Interrupt outputs
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdtIrq_r       <= 1'b0;
            lowSupplyIrq_r <= 1'b0;
        end
        else
        begin
            wdtIrq_r       <= wdtIrqFlag_r & wdtIrqMd;
            lowSupplyIrq_r <= lowFlag_r & monIrqEn_r;
        end
    end

    // ============================================================
    // APB read data and ready; one wait state per access
    reg [31:0] rdMux;
    reg        errMux;
    always @*
    begin
        rdMux  = 32'h00000000;
        errMux = 1'b0;
        if (paddr == `RSWC_OFS_WDT)
            rdMux[7:0] = {wdtIrqFlag_r, wdtIrqEn_r, wdtPre_r[3],
                          1'b0, wdtEnEff, wdtPre_r[2:0]};
        else if (paddr == `RSWC_OFS_MON)
            rdMux[7:0] = {lowFlag_r, monIrqEn_r, 3'h0,
                          supplyLevelSelect};
        else if (paddr == `RSWC_OFS_FLG)
            rdMux[7:0] = {4'h0, flagWdt_r, 1'b0,
                          flagExt_r, flagPor_r};
        else if (paddr == `RSWC_OFS_UNLK)
            rdMux = 32'h00000000;
        else
            errMux = 1'b1;
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            prdata  <= rdMux;
            pslverr <= psel & penable & ~pready & errMux;
        end
    end

endmodule // rswc_top

// ---- verif/rswc_chk.sv ----
// Purpose: Port-level checks of the reset and watchdog block
// Assumes: single clk_sys domain, rst_n active low
// Notes:   Bound to every rswc_top instance
// ============================================================
// Checker
module rswc_chk
#(
    parameter TOUT_CYC = 8
)
(
    // Clock and reset
    input wire       clk_sys,
    input wire       rst_n,
    // Supply and pin
    input wire       supplyBelowPot,
    input wire       supplyBelowLevel,
    input wire [2:0] supplyLevelSelect,
    input wire       resetPinN,
    input wire       extResetEnable,
    // Core side
    input wire       coreResetN_r,
    input wire       wdtIrq_r,
    input wire       lowSupplyIrq_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lowCnt_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Length of current internal reset; saturates, never wraps
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            lowCnt_r <= 16'h0000;
        else if (coreResetN_r)
            lowCnt_r <= 16'h0000;
        else if (lowCnt_r != 16'hffff)
            lowCnt_r <= lowCnt_r + 16'h0001;
    sequence s_supplyUp;
        !supplyBelowLevel [*3];
    endsequence
    sequence s_pinLowRun;
        extResetEnable && !resetPinN && $past(coreResetN_r);
    endsequence
    chk_pot_holds: assert property (
        supplyBelowPot |=> !coreResetN_r)
        else $error("Core reset not held on low supply");
    chk_delay_min: assert property (
        $rose(coreResetN_r) |-> lowCnt_r >= TOUT_CYC)
        else $error("Core released before start-up delay");
    chk_pin_async: assert property (
        s_pinLowRun |-> !coreResetN_r)
        else $error("Low pin did not reset core");
    chk_low_irq: assert property (
        $rose(lowSupplyIrq_r) |-> ($past(supplyBelowLevel)
        || $past(supplyBelowLevel, 2)) && (supplyLevelSelect == 3'h3
        || supplyLevelSelect == 3'h4))
        else $error("Low supply irq without cause");
    chk_flag_clear: assert property (
        s_supplyUp |-> !lowSupplyIrq_r)
        else $error("Low supply irq stuck after recovery");
    chk_level_legal: assert property (
        supplyLevelSelect <= 3'h4)
        else $error("Illegal monitor level accepted");
    chk_mon_reset: assert property (
        (supplyLevelSelect == 3'h1 || supplyLevelSelect == 3'h2)
        && supplyBelowLevel |-> ##[1:3] !coreResetN_r)
        else $error("Monitor reset level did not reset core");
    chk_rst_clears: assert property (
        !coreResetN_r [*3] |-> !wdtIrq_r)
        else $error("Watchdog irq survives reset");
endmodule // rswc_chk

bind rswc_top rswc_chk #(.TOUT_CYC(TOUT_CYC)) u_rswc_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .supplyBelowPot(supplyBelowPot),
    .supplyBelowLevel(supplyBelowLevel),
    .supplyLevelSelect(supplyLevelSelect), .resetPinN(resetPinN),
    .extResetEnable(extResetEnable), .coreResetN_r(coreResetN_r),
    .wdtIrq_r(wdtIrq_r), .lowSupplyIrq_r(lowSupplyIrq_r));

// ---- verif/rswc_core_model.sv ----
// Purpose: Core stand-in issuing restarts and irq service
// Assumes: restart gap far below the shortest watchdog period
// Notes:   Keeps the watchdog from expiring in short runs
// ============================================================
// Core model
module rswc_core_model
(
    // Clock and reset
    input  wire  clk_sys,
    input  wire  rst_n,
    // From block
    input  wire  coreResetN_r,
    input  wire  wdtIrq_r,
    // To block
    output logic wdtRestart,
    output logic wdtIrqAck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] gapCnt_r;
    // Periodic restart while running; ack pulsed every other cycle while irq is high
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gapCnt_r   <= 10'h000;
            wdtRestart <= 1'b0;
            wdtIrqAck  <= 1'b0;
        end
        else
        begin
            gapCnt_r   <= coreResetN_r ? gapCnt_r + 10'h001 : 10'h000;
            wdtRestart <= coreResetN_r && gapCnt_r == 10'h3ff;
            wdtIrqAck  <= wdtIrq_r && !wdtIrqAck;
        end
    end
endmodule // rswc_core_model

// ---- verif/tb_top.sv ----
// Purpose: Register-level tests of the reset and watchdog block
// Assumes: short start-up count via TOUT_CYC parameter
// Notes:   Watchdog expiry is too long to reach here
`include "rswc_defs.vh"
// ============================================================
// Bench
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TOUT = 8;
    logic        clk_sys, rst_n, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdq;
    logic        pready, pslverr, errq;
    logic        supplyBelowPot, supplyBelowLevel, resetPinN;
    logic        extResetEnable, wdtAlwaysOnFuse, wdtRestart, wdtIrqAck;
    logic        coreResetN_r, wdtIrq_r, lowSupplyIrq_r;
    logic [2:0]  supplyLevelSelect;
    int          fails = 0;
    int          checks_done = 0;
    int          n;
    bit          held = 0;
    rswc_top #(.TOUT_CYC(TOUT)) u_rswc_top (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supplyBelowPot(supplyBelowPot),
        .supplyBelowLevel(supplyBelowLevel),
        .supplyLevelSelect(supplyLevelSelect), .resetPinN(resetPinN),
        .extResetEnable(extResetEnable),
        .wdtAlwaysOnFuse(wdtAlwaysOnFuse), .wdtRestart(wdtRestart),
        .wdtIrqAck(wdtIrqAck), .coreResetN_r(coreResetN_r),
        .wdtIrq_r(wdtIrq_r), .lowSupplyIrq_r(lowSupplyIrq_r));
    rswc_core_model u_rswc_core_model (
        .clk_sys(clk_sys), .rst_n(rst_n), .coreResetN_r(coreResetN_r),
        .wdtIrq_r(wdtIrq_r), .wdtRestart(wdtRestart),
        .wdtIrqAck(wdtIrqAck));
    // Free-running system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic close_out();
        $display("Checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // One APB transfer; keep leaves psel up for a back-to-back setup
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, input bit keep);
        if (!held)
            @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Wait states come from the slave; only the hang guard ends a hang
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rdq  = prdata;
        errq = pslverr;
        held = keep;
        if (!keep)
        begin
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        xfer(1'b0, a, 32'h0, 1'b0);
        check(nm, rdq, e);
    endtask
    // Signature then the control write straight after it
    task automatic prot(input logic [31:0] d);
        xfer(1'b1, `RSWC_OFS_UNLK, {24'h0, `RSWC_UNLOCK_SIG}, 1'b1);
        xfer(1'b1, `RSWC_OFS_WDT, d, 1'b0);
    endtask
    task automatic waitUp();
        n = 0;
        while (coreResetN_r !== 1'b1 && n < 400)
        begin
            @(posedge clk_sys);
            n++;
        end
        // A release that never comes is a mismatch
        if (n >= 400)
            fails++;
    endtask
    task automatic rel();
        cyc(2);
        rst_n <= 1'b1;
        waitUp();
    endtask
    // Hang guard, well above the expected run length
    initial
    begin
        #500000;
        fails++;
        close_out();
    end
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        supplyBelowPot = 1'b0;
        supplyBelowLevel = 1'b0;
        resetPinN = 1'b1;
        extResetEnable = 1'b0;
        wdtAlwaysOnFuse = 1'b0;
        rel();
        rd(`RSWC_OFS_FLG, 32'h1, "power flag");
        rd(`RSWC_OFS_WDT, 32'h0, "wdt idle");
        wr(`RSWC_OFS_WDT, 32'h08);
        rd(`RSWC_OFS_WDT, 32'h08, "wdt on");
        wr(`RSWC_OFS_WDT, 32'h00);
        rd(`RSWC_OFS_WDT, 32'h08, "plain off");
        wr(`RSWC_OFS_WDT, 32'h29);
        rd(`RSWC_OFS_WDT, 32'h29, "free period");
        prot(32'h00);
        rd(`RSWC_OFS_WDT, 32'h00, "timed off");
        wr(`RSWC_OFS_WDT, 32'h08);
        wr(`RSWC_OFS_UNLK, {24'h0, `RSWC_UNLOCK_SIG});
        cyc(4);
        wr(`RSWC_OFS_WDT, 32'h00);
        rd(`RSWC_OFS_WDT, 32'h08, "late off");
        $display("Test watchdog level 1 done");
        rd(`RSWC_OFS_MON, 32'h0, "mon idle");
        wr(`RSWC_OFS_MON, 32'h43);
        supplyBelowLevel <= 1'b1;
        cyc(4);
        check("low irq", {31'h0, lowSupplyIrq_r}, 32'h1);
        rd(`RSWC_OFS_MON, 32'hc3, "flag set");
        wr(`RSWC_OFS_MON, 32'h43);
        rd(`RSWC_OFS_MON, 32'h43, "flag zeroed");
        supplyBelowLevel <= 1'b0;
        cyc(3);
        supplyBelowLevel <= 1'b1;
        cyc(3);
        rd(`RSWC_OFS_MON, 32'hc3, "flag again");
        supplyBelowLevel <= 1'b0;
        cyc(3);
        rd(`RSWC_OFS_MON, 32'h43, "flag recovered");
        wr(`RSWC_OFS_MON, 32'h45);
        rd(`RSWC_OFS_MON, 32'h43, "illegal level");
        check("level out", {29'h0, supplyLevelSelect}, 32'h3);
        wr(`RSWC_OFS_MON, 32'h01);
        supplyBelowLevel <= 1'b1;
        cyc(4);
        check("mon reset", {31'h0, coreResetN_r}, 32'h0);
        supplyBelowLevel <= 1'b0;
        waitUp();
        rd(`RSWC_OFS_MON, 32'h01, "mon kept");
        wr(`RSWC_OFS_MON, 32'h00);
        $display("Test supply monitor done");
        wr(`RSWC_OFS_FLG, 32'h0);
        rd(`RSWC_OFS_FLG, 32'h0, "flags cleared");
        extResetEnable <= 1'b1;
        resetPinN      <= 1'b0;
        cyc(2);
        check("pin reset", {31'h0, coreResetN_r}, 32'h0);
        resetPinN <= 1'b1;
        waitUp();
        check("pin delay", {31'h0, n >= TOUT}, 32'h1);
        rd(`RSWC_OFS_FLG, 32'h2, "pin flag");
        supplyBelowPot <= 1'b1;
        cyc(2);
        check("pot reset", {31'h0, coreResetN_r}, 32'h0);
        supplyBelowPot <= 1'b0;
        resetPinN      <= 1'b0;
        cyc(5);
        resetPinN <= 1'b1;
        waitUp();
        check("pin ignored", {31'h0, n + 5 <= TOUT + 4}, 32'h1);
        xfer(1'b0, `RSWC_OFS_FLG, 32'h0, 1'b0);
        check("pot flag", rdq & 32'h1, 32'h1);
        rd(8'h10, 32'h0, "unmapped data");
        check("unmapped err", {31'h0, errq}, 32'h1);
        $display("Test reset sources done");
        rst_n           <= 1'b0;
        wdtAlwaysOnFuse <= 1'b1;
        rel();
        rd(`RSWC_OFS_WDT, 32'h08, "fuse on");
        wr(`RSWC_OFS_WDT, 32'h01);
        rd(`RSWC_OFS_WDT, 32'h08, "plain period");
        prot(32'h01);
        rd(`RSWC_OFS_WDT, 32'h09, "timed period");
        $display("Test watchdog level 2 done");
        close_out();
    end
endmodule // tb_top
